/* fpc_unit.sv */
// Single-precision operation unit behind the custom-instruction port
//
// Contract
// - Operand is sign, 8-bit exponent biased by 127, 23-bit fraction.
// - Exponent zero means zero or subnormal; all ones means infinity or NaN.
// - Classify zero, subnormal, infinity and NaN from exponent and fraction.
// - Sign bit gives polarity except for NaN, whose sign is ignored.
// - Top fraction bit clear marks signaling NaN, set marks quiet NaN.
// - Normal significand is 24 bits with restored hidden one.
// - Nearest rounding picks closest value, ties go away from zero.
// - Truncation rounding picks the neighbour nearer zero.
// - Faithful rounding may pick either bracketing neighbour.
// - Comparisons treat positive and negative zero as equal.
// - Every comparison returns 0 when any input is NaN.
// - Min/max return non-NaN input; opposite zeros give -0 / +0.
// - Other float-result operations return NaN for any NaN input.
// - Divide: 0/0, inf/inf give NaN; 0/inf gives 0; inf/0 gives inf.
// - Add/sub: cancelling infinities give NaN; cancelling zeros give +0.
// - Multiply: zero times infinity gives NaN in either order.
// - Square root of -0 is -0; of anything below -0 is NaN.
// - Float-to-integer saturates to 0x7fffffff or 0x80000000.
// - Each infinity compares equal to itself.
// - Add, sub, mul, div, sqrt flush subnormal inputs and outputs to zero.
`timescale 1ns/1ps
`default_nettype none
module fpc_unit
  import fpc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Request from the core
  input wire logic start,
  input wire fpc_op_t op,
  input wire logic [31:0] dataa,
  input wire logic [31:0] datab,
  // Answer to the core
  output logic [31:0] result,
  output logic done,
  output logic busy
);

  typedef struct packed {
    fpc_state_t state;
    fpc_op_t op;
    logic [4:0] cnt;
    logic [26:0] rem;
    logic [25:0] quo;
    logic [47:0] rad;
    logic [23:0] dvs;
    logic signed [9:0] exp;
    logic sign;
    logic [31:0] result;
    logic done;
    logic busy;
  } fpc_regs_t;

  fpc_regs_t r_reg;
  fpc_regs_t r_next;
  fpc_cls_t ca;
  fpc_cls_t cb;

  ////////////////////////////////////////////////////////////////////////////
  // Operand classification

  fpc_class_if cls_if [2] ();

  assign cls_if[0].word = dataa;
  assign cls_if[1].word = datab;
  assign ca = cls_if[0].cls;
  assign cb = cls_if[1].cls;

  for (genvar gi = 0; gi < 2; gi++) begin : g_cls
    fpc_classify u_cls (
      .c(cls_if[gi])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Overflow to infinity and underflow to signed zero, never a subnormal
  function automatic logic [31:0] f_pack(input logic s, input logic signed [9:0] e,
                                         input logic [23:0] m);
    if (e >= EXP_OVF) begin
      return {s, INF_BODY};
    end else if (e <= EXP_UNF) begin
      return {s, ZERO_BODY};
    end
    return {s, e[7:0], m[FRACTION_FIELD_W-1:0]};
  endfunction

  // Ordering key: both zeros map to 0, infinities to their own extremes
  function automatic logic signed [31:0] f_key(input fpc_cls_t c);
    logic signed [31:0] mag;
    mag = {1'b0, c.biased_exponent_field, c.fraction_field};
    return c.sign ? -mag : mag;
  endfunction

  function automatic logic f_lt(input fpc_cls_t x, input fpc_cls_t y);
    return f_key(x) < f_key(y);
  endfunction

  function automatic logic f_eq(input fpc_cls_t x, input fpc_cls_t y);
    return f_key(x) == f_key(y);
  endfunction

  function automatic logic [31:0] f_minmax(input fpc_cls_t x, input fpc_cls_t y,
                                           input logic is_max);
    logic [31:0] wx;
    logic [31:0] wy;
    wx = {x.sign, x.biased_exponent_field, x.fraction_field};
    wy = {y.sign, y.biased_exponent_field, y.fraction_field};
    if (x.nan && y.nan) begin
      return QNAN_WORD;
    end else if (x.nan) begin
      return wy;
    end else if (y.nan) begin
      return wx;
    end else if (x.zero && y.zero) begin
      return is_max ? {x.sign & y.sign, ZERO_BODY} : {x.sign | y.sign, ZERO_BODY};
    end
    return (f_lt(x, y) ^ is_max) ? wx : wy;
  endfunction

  // Sticky bit keeps truncated subtraction inside one unit in the last place
  function automatic logic [31:0] f_add(input fpc_cls_t x, input fpc_cls_t y,
                                        input logic is_sub);
    logic sy;
    logic sl;
    logic ss;
    logic [7:0] d;
    logic [27:0] big;
    logic [27:0] sml;
    logic [27:0] sum;
    logic signed [9:0] e;
    sy = y.sign ^ is_sub;
    if (x.nan || y.nan) begin
      return QNAN_WORD;
    end else if (x.inf && y.inf) begin
      return (x.sign != sy) ? QNAN_WORD : {x.sign, INF_BODY};
    end else if (x.inf) begin
      return {x.sign, INF_BODY};
    end else if (y.inf) begin
      return {sy, INF_BODY};
    end else if (x.flush && y.flush) begin
      return {x.sign & sy, ZERO_BODY};
    end else if (x.flush) begin
      return {sy, y.biased_exponent_field, y.fraction_field};
    end else if (y.flush) begin
      return {x.sign, x.biased_exponent_field, x.fraction_field};
    end
    if ({x.biased_exponent_field, x.fraction_field} >=
        {y.biased_exponent_field, y.fraction_field}) begin
      sl = x.sign;
      ss = sy;
      d = x.biased_exponent_field - y.biased_exponent_field;
      big = {1'b0, x.sig, 3'b000};
      sml = {1'b0, y.sig, 3'b000};
      e = $signed({2'b00, x.biased_exponent_field});
    end else begin
      sl = sy;
      ss = x.sign;
      d = y.biased_exponent_field - x.biased_exponent_field;
      big = {1'b0, y.sig, 3'b000};
      sml = {1'b0, x.sig, 3'b000};
      e = $signed({2'b00, y.biased_exponent_field});
    end
    if (d >= 8'h1b) begin
      sml = 28'h0000001;
    end else begin
      sml = (sml >> d) | {27'h0, |(sml & ((28'h0000001 << d) - 28'h0000001))};
    end
    sum = (sl == ss) ? big + sml : big - sml;
    if (sum == 28'h0000000) begin
      return {1'b0, ZERO_BODY};
    end
    if (sum[27]) begin
      sum = sum >> 1;
      e = e + EXP_ONE;
    end
    for (int i = 0; i < 26; i++) begin
      if (!sum[26]) begin
        sum = sum << 1;
        e = e - EXP_ONE;
      end
    end
    return f_pack(sl, e, sum[26:3]);
  endfunction

  function automatic logic [31:0] f_mul(input fpc_cls_t x, input fpc_cls_t y);
    logic s;
    logic [47:0] p;
    logic signed [9:0] e;
    s = x.sign ^ y.sign;
    if (x.nan || y.nan) begin
      return QNAN_WORD;
    end else if ((x.inf && y.flush) || (x.flush && y.inf)) begin
      return QNAN_WORD;
    end else if (x.inf || y.inf) begin
      return {s, INF_BODY};
    end else if (x.flush || y.flush) begin
      return {s, ZERO_BODY};
    end
    p = x.sig * y.sig;
    e = $signed({2'b00, x.biased_exponent_field}) +
        $signed({2'b00, y.biased_exponent_field}) - EXP_BIAS;
    if (p[47]) begin
      return f_pack(s, e + EXP_ONE, p[47:24]);
    end
    return f_pack(s, e, p[46:23]);
  endfunction

  function automatic logic [31:0] f_fix(input fpc_cls_t x, input logic nearest);
    logic [63:0] t;
    logic [31:0] mag;
    if (x.nan) begin
      return INT_NAN_RES;
    end else if (x.flush) begin
      return CMP_FALSE;
    end else if (x.biased_exponent_field >= FIX_LIMIT) begin
      return x.sign ? INT_SAT_NEG : INT_SAT_POS;
    end
    t = {8'h00, x.sig, 32'h00000000};
    if (x.biased_exponent_field > FIX_POINT) begin
      t = t << (x.biased_exponent_field - FIX_POINT);
    end else begin
      t = t >> (FIX_POINT - x.biased_exponent_field);
    end
    // Half or more rounds away from zero; truncation drops the fraction
    mag = t[63:32] + {31'h0, nearest & t[31]};
    return x.sign ? -mag : mag;
  endfunction

  function automatic logic [31:0] f_single(input fpc_op_t o, input fpc_cls_t x,
                                           input fpc_cls_t y);
    logic any_nan;
    any_nan = x.nan | y.nan;
    case (o)
      OP_ADD: return f_add(x, y, 1'b0);
      OP_SUB: return f_add(x, y, 1'b1);
      OP_MUL: return f_mul(x, y);
      OP_FIX: return f_fix(x, 1'b0);
      OP_ROUND: return f_fix(x, 1'b1);
      OP_MIN: return f_minmax(x, y, 1'b0);
      OP_MAX: return f_minmax(x, y, 1'b1);
      OP_LT: return (!any_nan && f_lt(x, y)) ? CMP_TRUE : CMP_FALSE;
      OP_LE: return (!any_nan && !f_lt(y, x)) ? CMP_TRUE : CMP_FALSE;
      OP_GT: return (!any_nan && f_lt(y, x)) ? CMP_TRUE : CMP_FALSE;
      OP_GE: return (!any_nan && !f_lt(x, y)) ? CMP_TRUE : CMP_FALSE;
      OP_EQ: return (!any_nan && f_eq(x, y)) ? CMP_TRUE : CMP_FALSE;
      OP_NE: return (!any_nan && !f_eq(x, y)) ? CMP_TRUE : CMP_FALSE;
      OP_NEG: return {~x.sign, x.biased_exponent_field, x.fraction_field};
      OP_ABS: return {1'b0, x.biased_exponent_field, x.fraction_field};
      default: return QNAN_WORD;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: one-cycle operations answer next edge, divide and root iterate

  logic [26:0] sq_rem;
  logic [26:0] sq_try;
  logic [24:0] rnd;
  logic signed [9:0] e_fin;

  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    sq_rem = {r_reg.rem[24:0], r_reg.rad[47:46]};
    sq_try = {1'b0, r_reg.quo[23:0], 2'b01};
    rnd = 25'h0000000;
    e_fin = r_reg.exp;
    case (r_reg.state)
      ST_IDLE: begin
        if (start) begin
          r_next.op = op;
          r_next.sign = ca.sign ^ cb.sign;
          r_next.cnt = 5'h00;
          r_next.quo = 26'h0000000;
          r_next.done = 1'b1;
          r_next.result = f_single(op, ca, cb);
          if (op == OP_DIV) begin
            if (ca.nan || cb.nan) begin
              r_next.result = QNAN_WORD;
            end else if ((ca.flush && cb.flush) || (ca.inf && cb.inf)) begin
              r_next.result = QNAN_WORD;
            end else if (ca.flush || cb.inf) begin
              r_next.result = {ca.sign ^ cb.sign, ZERO_BODY};
            end else if (ca.inf || cb.flush) begin
              r_next.result = {ca.sign ^ cb.sign, INF_BODY};
            end else begin
              r_next.done = 1'b0;
              r_next.state = ST_DIV;
              r_next.rem = {3'b000, ca.sig};
              r_next.dvs = cb.sig;
              r_next.exp = $signed({2'b00, ca.biased_exponent_field}) -
                           $signed({2'b00, cb.biased_exponent_field}) + EXP_BIAS;
            end
          end else if (op == OP_SQRT) begin
            r_next.rem = 27'h0000000;
            if (ca.nan) begin
              r_next.result = QNAN_WORD;
            end else if (ca.flush) begin
              r_next.result = {ca.sign, ZERO_BODY};
            end else if (ca.sign) begin
              r_next.result = QNAN_WORD;
            end else if (ca.inf) begin
              r_next.result = {1'b0, INF_BODY};
            end else begin
              r_next.done = 1'b0;
              r_next.state = ST_SQRT;
              // Odd unbiased exponent folds one factor of two into the radicand
              if (ca.biased_exponent_field[0]) begin
                r_next.rad = {1'b0, ca.sig, 23'h000000};
                r_next.exp = ($signed({2'b00, ca.biased_exponent_field}) + EXP_BIAS) >>> 1;
              end else begin
                r_next.rad = {ca.sig, 24'h000000};
                r_next.exp = ($signed({2'b00, ca.biased_exponent_field}) - EXP_ONE +
                              EXP_BIAS) >>> 1;
              end
            end
          end
        end
      end
      ST_DIV: begin
        // Restoring division, one quotient bit per cycle
        if (r_reg.rem >= {3'b000, r_reg.dvs}) begin
          r_next.rem = (r_reg.rem - {3'b000, r_reg.dvs}) << 1;
          r_next.quo = {r_reg.quo[24:0], 1'b1};
        end else begin
          r_next.rem = r_reg.rem << 1;
          r_next.quo = {r_reg.quo[24:0], 1'b0};
        end
        r_next.cnt = r_reg.cnt + 5'h01;
        if (r_reg.cnt == DIV_STEPS - 5'h01) begin
          r_next.state = ST_FIN;
        end
      end
      ST_SQRT: begin
        // Digit-by-digit root, two radicand bits per cycle; remainder dropped
        if (sq_rem >= sq_try) begin
          r_next.rem = sq_rem - sq_try;
          r_next.quo = {r_reg.quo[24:0], 1'b1};
        end else begin
          r_next.rem = sq_rem;
          r_next.quo = {r_reg.quo[24:0], 1'b0};
        end
        r_next.rad = r_reg.rad << 2;
        r_next.cnt = r_reg.cnt + 5'h01;
        if (r_reg.cnt == SQRT_STEPS - 5'h01) begin
          r_next.state = ST_FIN;
        end
      end
      ST_FIN: begin
        r_next.state = ST_IDLE;
        r_next.done = 1'b1;
        if (r_reg.op == OP_DIV) begin
          // Guard bit alone decides: ties and above go up in magnitude
          if (r_reg.quo[25]) begin
            rnd = {1'b0, r_reg.quo[25:2]} + {24'h000000, r_reg.quo[1]};
          end else begin
            rnd = {1'b0, r_reg.quo[24:1]} + {24'h000000, r_reg.quo[0]};
            e_fin = r_reg.exp - EXP_ONE;
          end
          if (rnd[24]) begin
            rnd = rnd >> 1;
            e_fin = e_fin + EXP_ONE;
          end
          r_next.result = f_pack(r_reg.sign, e_fin, rnd[23:0]);
        end else begin
          r_next.result = f_pack(1'b0, r_reg.exp, r_reg.quo[23:0]);
        end
      end
      default: begin
        r_next.state = ST_IDLE;
      end
    endcase
    r_next.busy = (r_next.state != ST_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      r_reg <= '0;
      r_reg.state <= ST_IDLE;
      r_reg.op <= OP_ADD;
    end else begin
      r_reg <= r_next;
    end
  end

  assign result = r_reg.result;
  assign done = r_reg.done;
  assign busy = r_reg.busy;

endmodule
`default_nettype wire

/* fpc_pkg.sv */
// Shared constants and types for the single-precision operation unit
package fpc_pkg;

  // Word layout
  localparam int unsigned SIGN_POS = 31;
  localparam int unsigned EXP_MSB = 30;
  localparam int unsigned EXP_LSB = 23;
  localparam int unsigned FRACTION_FIELD_MSB = 22;
  localparam int unsigned FRACTION_FIELD_W = 23;
  localparam int unsigned SIG_W = 24;

  // Exponent codes and bias
  localparam logic [7:0] EXP_RESVD_LO = 8'h00;
  localparam logic [7:0] EXP_RESVD_HI = 8'hff;
  localparam logic [7:0] EXP_NORM_MAX = 8'hfe;
  localparam logic signed [9:0] EXP_BIAS = 10'sh07f;
  localparam logic signed [9:0] EXP_OVF = 10'sh0ff;
  localparam logic signed [9:0] EXP_UNF = 10'sh000;
  localparam logic signed [9:0] EXP_ONE = 10'sh001;

  // Fixed result words
  localparam logic [31:0] QNAN_WORD = 32'h7fc00000;
  localparam logic [30:0] INF_BODY = 31'h7f800000;
  localparam logic [30:0] ZERO_BODY = 31'h00000000;
  localparam logic [31:0] INT_SAT_POS = 32'h7fffffff;
  localparam logic [31:0] INT_SAT_NEG = 32'h80000000;
  localparam logic [31:0] INT_NAN_RES = 32'h00000000;
  localparam logic [31:0] CMP_TRUE = 32'h00000001;
  localparam logic [31:0] CMP_FALSE = 32'h00000000;

  // Float-to-integer: saturate from 2^31, binary point of sig at 2^(exp-150)
  localparam logic [7:0] FIX_LIMIT = 8'h9e;
  localparam logic [7:0] FIX_POINT = 8'h96;

  // Iterative step counts
  localparam logic [4:0] DIV_STEPS = 5'h1a;
  localparam logic [4:0] SQRT_STEPS = 5'h18;

  typedef enum logic [4:0] {
    OP_ADD = 5'h00, OP_SUB = 5'h01, OP_MUL = 5'h02, OP_DIV = 5'h03,
    OP_SQRT = 5'h04, OP_FIX = 5'h05, OP_ROUND = 5'h06, OP_MIN = 5'h07,
    OP_MAX = 5'h08, OP_LT = 5'h09, OP_LE = 5'h0a, OP_GT = 5'h0b,
    OP_GE = 5'h0c, OP_EQ = 5'h0d, OP_NE = 5'h0e, OP_NEG = 5'h0f,
    OP_ABS = 5'h10
  } fpc_op_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_DIV = 4'b0010,
    ST_SQRT = 4'b0100,
    ST_FIN = 4'b1000
  } fpc_state_t;

  // Operand classification
  typedef struct packed {
    logic sign;
    logic [7:0] biased_exponent_field;
    logic [22:0] fraction_field;
    logic [23:0] sig;
    logic zero;
    logic sub;
    logic inf;
    logic nan;
    logic snan;
    logic flush;
  } fpc_cls_t;

endpackage

/* fpc_class_if.sv */
// Operand word and its classification between unit and classifier
`timescale 1ns/1ps
`default_nettype none
interface fpc_class_if;
  import fpc_pkg::*;
  logic [31:0] word;
  fpc_cls_t cls;
  modport classifier (input word, output cls);
  modport user (output word, input cls);
endinterface
`default_nettype wire

/* fpc_classify.sv */
// Splits an operand word into fields and classes
`timescale 1ns/1ps
`default_nettype none
module fpc_classify
  import fpc_pkg::*;
(
  // Operand side
  fpc_class_if.classifier c
);

  logic exp_lo;
  logic exp_hi;
  logic fraction_field_nz;

  always_comb begin
    exp_lo = (c.word[EXP_MSB:EXP_LSB] == EXP_RESVD_LO);
    exp_hi = (c.word[EXP_MSB:EXP_LSB] == EXP_RESVD_HI);
    fraction_field_nz = |c.word[FRACTION_FIELD_MSB:0];
    c.cls.sign = c.word[SIGN_POS];
    c.cls.biased_exponent_field = c.word[EXP_MSB:EXP_LSB];
    c.cls.fraction_field = c.word[FRACTION_FIELD_MSB:0];
    c.cls.sig = {~exp_lo, c.word[FRACTION_FIELD_MSB:0]};
    c.cls.zero = exp_lo & ~fraction_field_nz;
    c.cls.sub = exp_lo & fraction_field_nz;
    c.cls.inf = exp_hi & ~fraction_field_nz;
    c.cls.nan = exp_hi & fraction_field_nz;
    c.cls.snan = exp_hi & fraction_field_nz & ~c.word[FRACTION_FIELD_MSB];
    // Arithmetic sees subnormals as signed zero
    c.cls.flush = exp_lo;
  end

endmodule
`default_nettype wire

/* fpc_unit_chk.sv */
// Assertion checker for the single-precision operation unit
`timescale 1ns/1ps
`default_nettype none
module fpc_unit_chk
  import fpc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Request
  input wire logic start,
  input wire fpc_op_t op,
  input wire logic [31:0] dataa,
  input wire logic [31:0] datab,
  // Answer
  input wire logic [31:0] result,
  input wire logic done,
  input wire logic busy
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  ////////////////////////////////////////////////////////////
  logic taken;
  logic a_nan, b_nan, a_zero, b_zero, a_inf, b_inf, ab_zero, is_cmp;

  function automatic logic is_nan(input logic [31:0] w);
    return (w[30:23] == 8'hff) && (w[22:0] != 23'h0);
  endfunction

  // Busy stays high through the finishing cycle, so idle alone marks a take
  assign taken = start && !busy;
  assign a_nan = is_nan(dataa);
  assign b_nan = is_nan(datab);
  // Exponent zero covers subnormals, which flushing ops see as zero
  assign a_zero = dataa[30:23] == 8'h00;
  assign b_zero = datab[30:23] == 8'h00;
  assign a_inf = dataa[30:0] == INF_BODY;
  assign b_inf = datab[30:0] == INF_BODY;
  assign ab_zero = (dataa[30:0] == ZERO_BODY) && (datab[30:0] == ZERO_BODY);
  assign is_cmp = op inside {OP_LT, OP_LE, OP_GT, OP_GE, OP_EQ, OP_NE};

  ////////////////////////////////////////////////////////////
  property p_cmp_nan;
    taken && is_cmp && (a_nan || b_nan) |=> done && result == CMP_FALSE;
  endproperty
  a_cmp_nan: assert property (p_cmp_nan) else $error("compare with NaN not 0");

  property p_cmp_zero_eq;
    taken && op inside {OP_LE, OP_GE, OP_EQ} && ab_zero |=> done && result == CMP_TRUE;
  endproperty
  a_cmp_zero_eq: assert property (p_cmp_zero_eq) else $error("zeros not equal");

  property p_cmp_zero_ne;
    taken && op inside {OP_LT, OP_GT, OP_NE} && ab_zero |=> done && result == CMP_FALSE;
  endproperty
  a_cmp_zero_ne: assert property (p_cmp_zero_ne) else $error("zeros ordered");

  property p_inf_self;
    taken && op == OP_EQ && a_inf && dataa == datab |=> result == CMP_TRUE;
  endproperty
  a_inf_self: assert property (p_inf_self) else $error("infinity not self equal");

  property p_minmax_nan;
    taken && op inside {OP_MIN, OP_MAX} && a_nan && !b_nan |=> result == $past(datab);
  endproperty
  a_minmax_nan: assert property (p_minmax_nan) else $error("min/max kept NaN");

  property p_arith_nan;
    taken && op inside {OP_ADD, OP_SUB, OP_MUL} && (a_nan || b_nan) |=> done && is_nan(result);
  endproperty
  a_arith_nan: assert property (p_arith_nan) else $error("NaN not propagated");

  property p_mul_zinf;
    taken && op == OP_MUL && ((a_zero && b_inf) || (a_inf && b_zero)) |=> is_nan(result);
  endproperty
  a_mul_zinf: assert property (p_mul_zinf) else $error("zero times inf not NaN");

  property p_div_zz;
    taken && op == OP_DIV && a_zero && b_zero |=> done && is_nan(result);
  endproperty
  a_div_zz: assert property (p_div_zz) else $error("zero over zero not NaN");

  property p_sqrt_neg;
    taken && op == OP_SQRT && dataa[31] && !a_zero && !a_nan |-> ##[1:30] done ##0 is_nan(result);
  endproperty
  a_sqrt_neg: assert property (p_sqrt_neg) else $error("root of negative not NaN");

  property p_fix_sat;
    taken && op inside {OP_FIX, OP_ROUND} && !dataa[31] && !a_nan && dataa[30:23] >= FIX_LIMIT
      |=> result == INT_SAT_POS;
  endproperty
  a_fix_sat: assert property (p_fix_sat) else $error("conversion not saturated");

  c_div: cover property (taken && op == OP_DIV && !a_zero && !b_zero);
  c_min_nan: cover property (taken && op == OP_MIN && a_nan);
  c_busy_end: cover property ($fell(busy));
endmodule

bind fpc_unit fpc_unit_chk i_fpc_unit_chk (
  .sys_clk(sys_clk),
  .srst(srst),
  .start(start),
  .op(op),
  .dataa(dataa),
  .datab(datab),
  .result(result),
  .done(done),
  .busy(busy)
);
`default_nettype wire

/* fpc_core_model.sv */
// Core-side model that issues one instruction at a time to the unit
`timescale 1ns/1ps
`default_nettype none
module fpc_core_model
  import fpc_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Request
  output logic start,
  output var fpc_op_t op,
  output logic [31:0] dataa,
  output logic [31:0] datab,
  // Answer
  input wire logic [31:0] result,
  input wire logic done
);
  initial begin
    start = 1'b0;
    op = OP_ADD;
    dataa = 32'h0;
    datab = 32'h0;
  end

  // Start is a one-cycle strobe; holding it would launch the op twice
  task automatic issue(input fpc_op_t o, input logic [31:0] a, input logic [31:0] b,
                       output logic [31:0] r, output bit late);
    int n;
    @(posedge sys_clk);
    start <= 1'b1;
    op <= o;
    dataa <= a;
    datab <= b;
    @(posedge sys_clk);
    start <= 1'b0;
    late = 1'b1;
    for (n = 0; n < 40 && late; n++) begin
      @(posedge sys_clk);
      if (done === 1'b1) begin
        r = result;
        late = 1'b0;
      end
    end
    // Released operands no longer show the last value
    dataa <= ~a;
    datab <= ~b;
  endtask
endmodule
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the single-precision operation unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fpc_pkg::*;
  logic sys_clk, srst, start, done, busy;
  fpc_op_t op;
  logic [31:0] dataa, datab, result;
  int n_mismatch, total_checks;

  fpc_unit i_fpc_unit (.sys_clk(sys_clk), .srst(srst), .start(start), .op(op),
    .dataa(dataa), .datab(datab), .result(result), .done(done), .busy(busy));
  fpc_core_model i_fpc_core_model (.sys_clk(sys_clk), .start(start), .op(op),
    .dataa(dataa), .datab(datab), .result(result), .done(done));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////
  task automatic summarize();
    if (n_mismatch == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  // Either bound is accepted; QNAN_WORD as lower bound accepts any NaN
  task automatic run2(input fpc_op_t o, input logic [31:0] a, input logic [31:0] b,
                      input logic [31:0] lo, input logic [31:0] hi);
    logic [31:0] r;
    bit late;
    i_fpc_core_model.issue(o, a, b, r, late);
    if (late) begin
      n_mismatch++;
      summarize();
    end else begin
      if (lo === QNAN_WORD && r[30:23] === 8'hff && (|r[22:0]) === 1'b1) lo = r;
      check(r, (r === hi) ? hi : lo);
    end
  endtask

  task automatic run(input fpc_op_t o, input logic [31:0] a, input logic [31:0] b,
                     input logic [31:0] e);
    run2(o, a, b, e, e);
  endtask

  ////////////////////////////////////////////////////////////
  task automatic t_format();
    run(OP_ADD, 32'h3f800000, 32'h3f800000, 32'h40000000);
    run(OP_MUL, 32'h3fc00000, 32'h3fc00000, 32'h40100000);
    run(OP_LT, 32'h7f7fffff, 32'h7f800000, CMP_TRUE);
    run(OP_GT, 32'h00000001, 32'h80000000, CMP_TRUE);
    run(OP_LT, 32'h80000001, 32'h00000000, CMP_TRUE);
    run(OP_EQ, 32'hffc00000, 32'hffc00000, CMP_FALSE);
    run(OP_MIN, 32'h7f800001, 32'h3f800000, 32'h3f800000);
    run(OP_NEG, 32'h3f800000, 32'h0, 32'hbf800000);
    run(OP_ABS, 32'hff800000, 32'h0, 32'h7f800000);
  endtask

  task automatic t_compare();
    logic [31:0] pa [6] = '{32'h00000000, 32'h80000000, 32'h7f800000, 32'hff800000,
                            32'hffc00000, 32'h3f800000};
    logic [31:0] pb [6] = '{32'h80000000, 32'h00000000, 32'h7f800000, 32'hff800000,
                            32'h3f800000, 32'h7f800001};
    for (int i = 0; i < 6; i++) begin
      for (int k = 0; k < 6; k++) begin
        run(fpc_op_t'(5'h09 + 5'(k)), pa[i], pb[i],
            (i < 4 && (k == 1 || k == 3 || k == 4)) ? CMP_TRUE : CMP_FALSE);
      end
    end
  endtask

  task automatic t_minmax();
    run(OP_MIN, 32'h00000000, 32'h80000000, 32'h80000000);
    run(OP_MIN, 32'h80000000, 32'h00000000, 32'h80000000);
    run(OP_MAX, 32'h00000000, 32'h80000000, 32'h00000000);
    run(OP_MAX, 32'h80000000, 32'h00000000, 32'h00000000);
    run(OP_MAX, 32'h40000000, 32'h7fc00000, 32'h40000000);
    run(OP_MIN, 32'h7fc00000, 32'hffc00001, QNAN_WORD);
    run(OP_MIN, 32'h00000001, 32'h00000002, 32'h00000001);
  endtask

  task automatic t_special();
    run(OP_DIV, 32'h00000000, 32'h80000000, QNAN_WORD);
    run(OP_DIV, 32'h7f800000, 32'hff800000, QNAN_WORD);
    run(OP_DIV, 32'h00000000, 32'h7f800000, 32'h00000000);
    run(OP_DIV, 32'h7f800000, 32'h00000000, 32'h7f800000);
    run(OP_DIV, 32'h7fc00000, 32'h3f800000, QNAN_WORD);
    run(OP_ADD, 32'h7f800000, 32'hff800000, QNAN_WORD);
    run(OP_SUB, 32'hff800000, 32'hff800000, QNAN_WORD);
    run(OP_ADD, 32'h80000000, 32'h00000000, 32'h00000000);
    run(OP_SUB, 32'h80000000, 32'h80000000, 32'h00000000);
    run(OP_SUB, 32'h3f800000, 32'h7f800001, QNAN_WORD);
    run(OP_MUL, 32'h00000000, 32'hff800000, QNAN_WORD);
    run(OP_MUL, 32'h7f800000, 32'h80000000, QNAN_WORD);
    run(OP_SQRT, 32'h80000000, 32'h0, 32'h80000000);
    run(OP_SQRT, 32'hbf800000, 32'h0, QNAN_WORD);
    run(OP_SQRT, 32'hff800000, 32'h0, QNAN_WORD);
    run(OP_SQRT, 32'h7fc00000, 32'h0, QNAN_WORD);
  endtask

  task automatic t_round();
    run(OP_DIV, 32'h3f800000, 32'h40400000, 32'h3eaaaaab);
    run(OP_DIV, 32'hbf800000, 32'h40400000, 32'hbeaaaaab);
    run(OP_ROUND, 32'h40200000, 32'h0, 32'h00000003);
    run(OP_ROUND, 32'hc0200000, 32'h0, 32'hfffffffd);
    run(OP_FIX, 32'h40200000, 32'h0, 32'h00000002);
    run(OP_FIX, 32'hc0200000, 32'h0, 32'hfffffffe);
    run2(OP_ADD, 32'h3f800000, 32'h33c00000, 32'h3f800000, 32'h3f800001);
    run2(OP_SQRT, 32'h40000000, 32'h0, 32'h3fb504f3, 32'h3fb504f4);
    run(OP_FIX, 32'h4f000000, 32'h0, INT_SAT_POS);
    run(OP_FIX, 32'h7f800000, 32'h0, INT_SAT_POS);
    run(OP_FIX, 32'hcf800000, 32'h0, INT_SAT_NEG);
    run(OP_ROUND, 32'hff800000, 32'h0, INT_SAT_NEG);
    run(OP_FIX, 32'hcf000000, 32'h0, INT_SAT_NEG);
  endtask

  // Subnormals read as signed zero and are never produced
  task automatic t_flush();
    run(OP_ADD, 32'h00400000, 32'h00400000, 32'h00000000);
    run(OP_MUL, 32'h80000001, 32'h40000000, 32'h80000000);
    run(OP_MUL, 32'h00800000, 32'h3f000000, 32'h00000000);
    run(OP_DIV, 32'h00000001, 32'h3f800000, 32'h00000000);
    run(OP_SQRT, 32'h00000001, 32'h0, 32'h00000000);
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1;
    n_mismatch = 0;
    total_checks = 0;
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    check({done, busy, result[29:0]}, 32'h0);
    t_format();
    t_compare();
    t_minmax();
    t_special();
    t_round();
    t_flush();
    summarize();
  end
endmodule
`default_nettype wire
